/* sfc_pkg.sv */
// Constants for the synthesizer frequency control block.
// Assumes a 100 MHz system clock and an external serial register decoder.
package sfc_pkg;
   // *********************************************************
   // Register offsets and reset values.
   // *********************************************************
   localparam logic [6:0] ADDR_OFS_LO  = 7'h73;
   localparam logic [6:0] ADDR_OFS_HI  = 7'h74;
   localparam logic [6:0] ADDR_BAND    = 7'h75;
   localparam logic [6:0] ADDR_CAR_HI  = 7'h76;
   localparam logic [6:0] ADDR_CAR_LO  = 7'h77;
   localparam logic [6:0] ADDR_HOP_CH  = 7'h79;
   localparam logic [6:0] ADDR_HOP_ST  = 7'h7A;
   localparam logic [7:0] RST_BAND     = 8'h35;
   localparam logic [7:0] RST_CAR_HI   = 8'hBB;
   localparam logic [7:0] RST_CAR_LO   = 8'h80;
   localparam int         BAND_HB_BIT  = 5;
   localparam int         BAND_SB_BIT  = 6;
   localparam logic [4:0] BAND_MAX     = 5'h17;
   localparam int         N_BASE       = 24;
   // *********************************************************
   // Frequency scaling; clocks in hertz, the X16 terms in sixteenths of a hertz.
   // *********************************************************
   localparam int SYS_HZ       = 100_000_000;
   localparam int REF_HZ       = 10_000_000;
   localparam int REF_DIV      = SYS_HZ / REF_HZ;
   localparam int FRAC_MOD     = 64000;
   localparam int STEP_HZ_X16  = (REF_HZ / FRAC_MOD) * 16 + 4;
   localparam int IF_HZ_X16    = 15_000_000;
   localparam int HOP_HZ_X16   = 160_000;
   localparam int IF_UNITS_LB  = IF_HZ_X16 / STEP_HZ_X16;
   localparam int HOP_UNITS_LB = HOP_HZ_X16 / STEP_HZ_X16;
endpackage

/* sfc_top.sv */
// Synthesizer frequency control: registers to fractional-N division ratio.
// Assumes a serial port decoder delivering byte reads and writes, and a
// mode sequencer on the same clock supplying receive and tune requests.
`timescale 1ns/1ps
`default_nettype none
module sfc_top
   import sfc_pkg::*;
(
   input  wire logic       sys_clk_i,      // 100 MHz clock.
   input  wire logic       nrst_i,         // Async reset, active low.
   input  wire logic       reg_wr_i,       // Register write strobe.
   input  wire logic       reg_rd_i,       // Register read strobe.
   input  wire logic [6:0] reg_addr_i,     // Register address.
   input  wire logic [7:0] reg_wdata_i,    // Write data.
   output logic      [7:0] reg_rdata_o,    // Read data, registered.
   input  wire logic       rx_on_i,        // Receive state active.
   input  wire logic       pll_on_i,       // Tune state requested.
   input  wire logic       afc_en_i,       // Correction loop enabled.
   input  wire logic [9:0] afc_value_i,    // Correction loop value.
   input  wire logic [7:0] deviation_value_i, // Deviation magnitude.
   input  wire logic       mod_data_i,     // Modulating data bit.
   output logic      [6:0] int_ratio_o,    // Integer ratio N.
   output logic     [15:0] frac_ratio_o,   // Fraction F times 64000.
   output logic      [7:0] div_ratio_o,    // Instantaneous divide value.
   output logic            halve_o,        // Output divide-by-two on.
   output logic            synth_en_o,     // Synthesizer enable.
   output logic            xtal_en_o,      // Crystal oscillator enable.
   output logic            vco_cal_o,      // Oscillator calibrate pulse.
   output logic            return_tune_o   // Force tune state pulse.
);
   // *********************************************************
   // Reset release and register file.
   // *********************************************************
   logic        rst_m, rst_n;
   logic [9:0]  signed_offset_value;
   logic [7:0]  band_reg;
   logic [15:0] carrier_fraction_word;
   logic [7:0]  hop_channel, hop_step;
   logic        wr_freq, wr_hop;

   // Reset is released through two flops so all logic leaves it together.
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         rst_m <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_m <= 1'b1;
         rst_n <= rst_m;
      end
   end

   assign wr_hop  = reg_wr_i && (reg_addr_i == ADDR_HOP_CH ||
                                 reg_addr_i == ADDR_HOP_ST);
   assign wr_freq = wr_hop || (reg_wr_i && reg_addr_i >= ADDR_OFS_LO &&
                               reg_addr_i <= ADDR_CAR_LO);

   // Register writes; the band index saturates rather than wrapping.
   always_ff @(posedge sys_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         signed_offset_value   <= '0;
         band_reg              <= RST_BAND;
         carrier_fraction_word <= {RST_CAR_HI, RST_CAR_LO};
         hop_channel           <= '0;
         hop_step              <= '0;
      end
      else if (reg_wr_i)
      begin
         unique case (reg_addr_i)
            ADDR_OFS_LO: signed_offset_value[7:0] <= reg_wdata_i;
            ADDR_OFS_HI: signed_offset_value[9:8] <= reg_wdata_i[1:0];
            ADDR_BAND:
            begin
               band_reg[6:5] <= reg_wdata_i[6:5];
               band_reg[4:0] <= (reg_wdata_i[4:0] > BAND_MAX) ?
                                BAND_MAX : reg_wdata_i[4:0];
            end
            ADDR_CAR_HI: carrier_fraction_word[15:8] <= reg_wdata_i;
            ADDR_CAR_LO: carrier_fraction_word[7:0]  <= reg_wdata_i;
            ADDR_HOP_CH: hop_channel <= reg_wdata_i;
            ADDR_HOP_ST: hop_step    <= reg_wdata_i;
            default: ;
         endcase
      end
   end

   // Reads return stored fields; reserved bits and holes read zero.
   always_ff @(posedge sys_clk_i or negedge rst_n)
   begin
      if (!rst_n)
         reg_rdata_o <= '0;
      else if (reg_rd_i)
      begin
         unique case (reg_addr_i)
            ADDR_OFS_LO: reg_rdata_o <= signed_offset_value[7:0];
            ADDR_OFS_HI: reg_rdata_o <= {6'h00, signed_offset_value[9:8]};
            ADDR_BAND:   reg_rdata_o <= {1'b0, band_reg[6:0]};
            ADDR_CAR_HI: reg_rdata_o <= carrier_fraction_word[15:8];
            ADDR_CAR_LO: reg_rdata_o <= carrier_fraction_word[7:0];
            ADDR_HOP_CH: reg_rdata_o <= hop_channel;
            ADDR_HOP_ST: reg_rdata_o <= hop_step;
            default:     reg_rdata_o <= 8'h00;
         endcase
      end
   end

   // *********************************************************
   // Division ratio in units of one 64000th of the reference.
   // *********************************************************
   logic              hb;
   logic        [9:0] ofs_sel;
   logic signed [24:0] base_units, hop_units, if_units, ofs_units;
   logic signed [24:0] dev_units, next_num;
   logic signed [24:0] num;

   assign hb = band_reg[BAND_HB_BIT];
   // One shared offset: the correction loop owns it when enabled.
   assign ofs_sel = afc_en_i ? afc_value_i : signed_offset_value;
   // One unit is 156.25 Hz times the band factor, so the offset needs
   // no scaling and its sign is simply extended.
   assign ofs_units = 25'($signed(ofs_sel));
   // Hop frequency is converted to units; high band units are twice as
   // coarse, so the term halves there. Exact because 64 is even.
   assign hop_units = 25'((32'(hop_step) * 32'(hop_channel) *
                           HOP_UNITS_LB) >> hb);
   // Low-side injection: the centre frequency is programmed, and the
   // LO sits one IF below it only while receiving.
   assign if_units = rx_on_i ? 25'(IF_UNITS_LB >> hb) : '0;
   assign dev_units = mod_data_i ? 25'(deviation_value_i) :
                                   -25'(deviation_value_i);
   assign base_units = 25'((32'(band_reg[4:0]) + N_BASE) * FRAC_MOD +
                           32'(carrier_fraction_word));
   assign next_num = base_units + hop_units + ofs_units + dev_units -
                     if_units;

   // Ratio is recomputed every cycle, so any write shows two edges later.
   always_ff @(posedge sys_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         num          <= '0;
         int_ratio_o  <= '0;
         frac_ratio_o <= '0;
      end
      else
      begin
         num          <= next_num;
         int_ratio_o  <= 7'(num / FRAC_MOD);
         frac_ratio_o <= 16'(num % FRAC_MOD);
      end
   end

   // *********************************************************
   // Third order cascade modulator on the 10 MHz reference tick.
   // *********************************************************
   logic [3:0]  ref_cnt;
   logic        ref_tick;
   logic [15:0] acc [3];
   logic [2:0]  carry;
   logic [2:0]  c2d, c3d;

   assign ref_tick = (ref_cnt == 4'(REF_DIV - 1));

   always_ff @(posedge sys_clk_i or negedge rst_n)
   begin
      if (!rst_n)
         ref_cnt <= '0;
      else
         ref_cnt <= ref_tick ? '0 : ref_cnt + 4'h1;
   end

   // Stage 0 integrates the fraction; each later stage the residue of the one before it.
   genvar g;
   generate
      for (g = 0; g < 3; g++)
      begin : g_stage
         logic [16:0] sum;
         assign sum = 17'(acc[g]) + ((g == 0) ? 17'(frac_ratio_o) :
                                     17'(acc[g == 0 ? 0 : g - 1]));
         assign carry[g] = (sum >= 17'(FRAC_MOD));
         always_ff @(posedge sys_clk_i or negedge rst_n)
         begin
            if (!rst_n)
               acc[g] <= '0;
            else if (ref_tick)
               acc[g] <= carry[g] ? 16'(sum - 17'(FRAC_MOD)) :
                                    16'(sum);
         end
      end
   endgenerate

   // Noise-shaping recombination of the carries into a divide value.
   always_ff @(posedge sys_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         c2d         <= '0;
         c3d         <= '0;
         div_ratio_o <= '0;
      end
      else if (ref_tick)
      begin
         c2d         <= {c2d[1:0], carry[1]};
         c3d         <= {c3d[1:0], carry[2]};
         div_ratio_o <= 8'(10'(int_ratio_o) + 10'(carry[0]) +
                           10'(carry[1]) - 10'(c2d[0]) + 10'(carry[2]) -
                           10'({c3d[0], 1'b0}) + 10'(c3d[1]));
      end
   end

   // *********************************************************
   // Band divider, tune state and calibration requests.
   // *********************************************************
   logic cal_boot;

   // A hop retune during receive is signalled back to the sequencer;
   // calibration follows every frequency register write and the first cycle.
   always_ff @(posedge sys_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cal_boot      <= 1'b1;
         vco_cal_o     <= 1'b0;
         return_tune_o <= 1'b0;
         halve_o       <= 1'b1;
         synth_en_o    <= 1'b0;
         xtal_en_o     <= 1'b0;
      end
      else
      begin
         cal_boot      <= 1'b0;
         vco_cal_o     <= cal_boot || wr_freq;
         return_tune_o <= wr_hop && rx_on_i;
         halve_o       <= !hb;
         synth_en_o    <= pll_on_i || rx_on_i;
         xtal_en_o     <= pll_on_i || rx_on_i;
      end
   end

   // *********************************************************
   // Assertions.
   // *********************************************************
   // The ratio outputs trail reset by two edges, so the range check waits
   // until they have been loaded from real register contents.
   logic [1:0] ratio_age;

   always_ff @(posedge sys_clk_i or negedge rst_n)
   begin
      if (!rst_n)
         ratio_age <= '0;
      else if (ratio_age != 2'h3)
         ratio_age <= ratio_age + 2'h1;
   end

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n);

   sequence s_tick_gap;
      ref_tick ##1 (!ref_tick)[*8] ##1 !ref_tick ##1 ref_tick;
   endsequence

   a_band_sat: assert property (
      reg_wr_i && reg_addr_i == ADDR_BAND &&
      reg_wdata_i[4:0] > BAND_MAX |=> band_reg[4:0] == BAND_MAX)
      else $error("Band index did not saturate.");
   a_ref_period: assert property (ref_tick |-> s_tick_gap)
      else $error("Reference tick period wrong.");
   a_acc_wrap: assert property (acc[0] < 16'(FRAC_MOD) &&
      acc[1] < 16'(FRAC_MOD) && acc[2] < 16'(FRAC_MOD))
      else $error("Accumulator beyond modulus.");
   a_hop_tune: assert property (wr_hop && rx_on_i |=> return_tune_o)
      else $error("Hop write in receive gave no retune.");
   a_tune_cause: assert property (return_tune_o |-> $past(rx_on_i))
      else $error("Retune outside receive.");
   a_cal_change: assert property (wr_freq |=> vco_cal_o)
      else $error("No calibration after frequency write.");
   a_halve_band: assert property (!hb |=> halve_o)
      else $error("Low band not halved.");
   a_tune_xtal: assert property (
      pll_on_i |=> xtal_en_o && synth_en_o)
      else $error("Tune state left crystal or synthesizer off.");
   a_if_shift: assert property ($rose(rx_on_i) && $stable(next_num +
      if_units) |-> next_num == $past(next_num) - 25'(IF_UNITS_LB >> hb))
      else $error("Receive entry did not apply IF shift.");
   a_ratio_int: assert property (
      ratio_age == 2'h3 |-> int_ratio_o >= 7'(N_BASE) - 7'h01)
      else $error("Integer ratio below band base.");
endmodule
`default_nettype wire

/* sfc_host.sv */
// Host model: byte-wide register writes and reads into the block.
// Assumes the bench calls its tasks; strobes are sampled on rising edges.
`timescale 1ns/1ps
`default_nettype none
module sfc_host
(
   input  wire logic       clk_i,   // System clock.
   input  wire logic [7:0] rdata_i, // Registered read data.
   output logic            wr_o,    // Write strobe.
   output logic            rd_o,    // Read strobe.
   output logic      [6:0] addr_o,  // Register address.
   output logic      [7:0] wdata_o  // Write data.
);
   // The bus is idle from time zero.
   initial
   begin
      wr_o = 1'b0;
      rd_o = 1'b0;
      addr_o = 7'h00;
      wdata_o = 8'h00;
   end
   // One write; lines flip afterwards so no stale value looks valid.
   // Offsets handed in stay inside the band's adjustment range.
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(negedge clk_i);
      wr_o = 1'b1;
      addr_o = a;
      wdata_o = d;
      @(negedge clk_i);
      wr_o = 1'b0;
      addr_o = ~a;
      wdata_o = ~d;
   endtask
   // One read; data is taken on the falling edge after the strobe edge.
   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      @(negedge clk_i);
      rd_o = 1'b1;
      addr_o = a;
      @(negedge clk_i);
      rd_o = 1'b0;
      addr_o = ~a;
      d = rdata_i;
   endtask
endmodule
`default_nettype wire

/* testbench.sv */
// Self-checking bench for the frequency control block.
// Assumes the host model drives the register port; the bench plays sequencer.
`timescale 1ns/1ps
`default_nettype none
module testbench
   import sfc_pkg::*;
;
   logic              clk;
   logic              nrst;
   logic              wr;
   logic              rd;
   logic        [6:0] addr;
   logic        [7:0] wdata;
   logic        [7:0] rdata;
   logic              rx_on;
   logic              pll_on;
   logic              corr_en;
   logic        [9:0] corr_val;
   logic        [7:0] deviation_value;
   logic              mod_bit;
   logic        [6:0] n_int;
   logic       [15:0] n_frac;
   logic        [7:0] div_val;
   logic              halve;
   logic              synth_en;
   logic              xtal_en;
   logic              vco_cal;
   logic              ret_tune;
   logic        [7:0] rv;
   logic signed [9:0] signed_offset_value;
   int                err_total;
   int                total_checks;
   int                cyc;
   int                cal_cnt;
   int                tune_cnt;
   int                band_index = 21;
   int                hi_band = 1;
   int                carrier_fraction_word = 16'hBB80;
   int                hop_step;
   int                hop_chan;
   sfc_top sfc_top_i (.sys_clk_i(clk), .nrst_i(nrst), .reg_wr_i(wr),
      .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_rdata_o(rdata), .rx_on_i(rx_on), .pll_on_i(pll_on),
      .afc_en_i(corr_en), .afc_value_i(corr_val),
      .deviation_value_i(deviation_value), .mod_data_i(mod_bit),
      .int_ratio_o(n_int), .frac_ratio_o(n_frac), .div_ratio_o(div_val),
      .halve_o(halve), .synth_en_o(synth_en), .xtal_en_o(xtal_en),
      .vco_cal_o(vco_cal), .return_tune_o(ret_tune));
   sfc_host sfc_host_i (.clk_i(clk), .rdata_i(rdata), .wr_o(wr), .rd_o(rd),
      .addr_o(addr), .wdata_o(wdata));
   // 100 MHz clock.
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Pulse counters and a cycle ceiling so a hang cannot stall the run.
   always @(posedge clk)
   begin
      cyc++;
      if (vco_cal === 1'b1)
         cal_cnt++;
      if (ret_tune === 1'b1)
         tune_cnt++;
      if (cyc == 5000)
      begin
         err_total++;
         test_done();
      end
   end
   task automatic test_done();
      $display("Checks %0d, mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] e, logic [31:0] g);
      total_checks++;
      if (g !== e)
      begin
         err_total++;
         $display("[ERR] %s expected %0h seen %0h", s, e, g);
      end
   endtask
   // Expected numerator, worked out from the shadow copy of the registers.
   function automatic int exp_num();
      logic signed [9:0] ofs;
      int                n;
      ofs = corr_en ? corr_val : signed_offset_value;
      n = (band_index + N_BASE) * FRAC_MOD + carrier_fraction_word;
      n = n + ((hop_step * hop_chan * 64) >> hi_band) + int'(ofs);
      n = mod_bit ? n + int'(deviation_value) : n - int'(deviation_value);
      if (rx_on)
         n = n - (6000 >> hi_band);
      return n;
   endfunction
   task automatic chk_ratio();
      int e;
      repeat (4) @(negedge clk);
      e = exp_num();
      chk("int_ratio", e / FRAC_MOD, {25'h0, n_int});
      chk("frac_ratio", e % FRAC_MOD, {16'h0, n_frac});
      chk("halve", !hi_band, halve);
   endtask
   task automatic set_band(input int b, input int h, input logic [7:0] w);
      sfc_host_i.wr(ADDR_BAND, w);
      band_index = b;
      hi_band = h;
   endtask
   task automatic t_reset();
      logic [6:0] ra [8];
      logic [7:0] ev [8];
      ra = '{ADDR_OFS_LO, ADDR_OFS_HI, ADDR_BAND, ADDR_CAR_HI, ADDR_CAR_LO,
             ADDR_HOP_CH, ADDR_HOP_ST, 7'h78};
      ev = '{8'h00, 8'h00, 8'h35, 8'hBB, 8'h80, 8'h00, 8'h00, 8'h00};
      chk("powerup_cal", 1, cal_cnt);
      for (int i = 0; i < 8; i++)
      begin
         sfc_host_i.rd(ra[i], rv);
         chk("reset_reg", ev[i], rv);
      end
      chk_ratio();
      $display("test reset done");
   endtask
   task automatic t_band();
      set_band(23, 1, 8'hFF);
      sfc_host_i.rd(ADDR_BAND, rv);
      chk("band_sat", 8'h77, rv);
      chk_ratio();
      chk("band_cal", 2, cal_cnt);
      set_band(0, 0, 8'h40);
      chk_ratio();
      $display("test band done");
   endtask
   task automatic t_hop();
      sfc_host_i.wr(ADDR_CAR_HI, 8'hF9);
      sfc_host_i.wr(ADDR_CAR_LO, 8'hF0);
      sfc_host_i.wr(ADDR_HOP_ST, 8'h03);
      sfc_host_i.wr(ADDR_HOP_CH, 8'h05);
      carrier_fraction_word = 16'hF9F0;
      hop_step = 3;
      hop_chan = 5;
      chk_ratio();
      set_band(7, 1, 8'h27);
      chk_ratio();
      $display("test hop done");
   endtask
   task automatic t_offset();
      // Manual offset is only written while the correction loop is off.
      corr_en = 1'b0;
      sfc_host_i.wr(ADDR_OFS_HI, 8'hFF);
      sfc_host_i.rd(ADDR_OFS_HI, rv);
      chk("ofs_hi", 8'h03, rv);
      sfc_host_i.wr(ADDR_OFS_LO, 8'h60);
      signed_offset_value = 10'h360;
      chk_ratio();
      set_band(7, 0, 8'h07);
      chk_ratio();
      corr_val = 10'h0A0;
      corr_en = 1'b1;
      chk_ratio();
      corr_en = 1'b0;
      $display("test offset done");
   endtask
   task automatic t_rx();
      rx_on = 1'b1;
      chk_ratio();
      sfc_host_i.wr(ADDR_HOP_CH, 8'h02);
      hop_chan = 2;
      chk_ratio();
      chk("tune_pulse", 1, tune_cnt);
      rx_on = 1'b0;
      sfc_host_i.wr(ADDR_HOP_ST, 8'h01);
      hop_step = 1;
      chk_ratio();
      chk("no_tune_pulse", 1, tune_cnt);
      $display("test rx done");
   endtask
   task automatic t_dev_en();
      deviation_value = 8'h19;
      chk_ratio();
      mod_bit = 1'b1;
      chk_ratio();
      pll_on = 1'b1;
      repeat (3) @(negedge clk);
      chk("synth_en", 1, synth_en);
      chk("xtal_en", 1, xtal_en);
      pll_on = 1'b0;
      repeat (3) @(negedge clk);
      chk("synth_off", 0, synth_en);
      $display("test deviation and tune done");
   endtask
   // The modulator output must average to the programmed ratio. Carries of
   // the later stages telescope, so a window's sum strays by a few counts.
   task automatic t_mod();
      int e;
      int sum;
      int bad;
      int want;
      int n_lo;
      e = exp_num();
      sum = 0;
      bad = 0;
      n_lo = e / FRAC_MOD;
      repeat (10) @(negedge clk);
      for (int i = 0; i < 64; i++)
      begin
         repeat (10) @(negedge clk);
         sum = sum + int'(div_val);
         if (int'(div_val) < n_lo - 3 || int'(div_val) > n_lo + 4)
            bad++;
      end
      want = 64 * n_lo + (64 * (e % FRAC_MOD)) / FRAC_MOD;
      if (sum >= want - 5 && sum <= want + 5)
         sum = want;
      chk("mod_range", 0, bad);
      chk("mod_mean", want, sum);
      $display("test modulator done");
   endtask
   // Main sequence.
   initial
   begin
      nrst = 1'b0;
      rx_on = 1'b0;
      pll_on = 1'b0;
      corr_en = 1'b0;
      corr_val = 10'h000;
      deviation_value = 8'h00;
      mod_bit = 1'b0;
      signed_offset_value = 10'h000;
      repeat (5) @(negedge clk);
      nrst = 1'b1;
      repeat (5) @(negedge clk);
      t_reset();
      t_band();
      t_hop();
      t_offset();
      t_rx();
      t_dev_en();
      t_mod();
      test_done();
   end
endmodule
`default_nettype wire
